// ===== eps_pkg.sv
// Package with constants and types for the PROM word program sequencer.
// What this block does
// - Drive write data; return read data when enabled
// - Separate read and program start inputs
// - Check address range first; abort on error
// - Valid read asserts data enable, then completes
// - No high voltage aborts a program with hardware error
// - Program begins by raising read/program select
// - Then raise address-invert select
// - 110 us later raise gate-supply pulse
// - 72 us later lower address invert
// - 72 us later raise program-supply pulse
// - Hold 2.8 ms, then lower program pulse
// - 21 us later lower gate-supply pulse
// - 21 us later lower read/program select
// - Rest 12.5 ms between program cycles
// - Compare after each cycle; fail after 49
// - After success on N, 4N+5 more cycles
// - Address error when top four bits nonzero
package eps_pkg;

   // ****************************************************************
   // Timing constants
   // ****************************************************************
   localparam int CLK_HZ        = 20_000_000;
   localparam int T_INV_GATE_NS = 110_000;
   localparam int T_GATE_ADR_NS = 72_000;
   localparam int T_ADR_PROG_NS = 72_000;
   localparam int T_PULSE_NS    = 2_800_000;
   localparam int T_END_GATE_NS = 21_000;
   localparam int T_GATE_SEL_NS = 21_000;
   localparam int T_REST_NS     = 12_500_000;
   localparam int NS_PER_CLK    = 1_000_000_000 / CLK_HZ;

   // Approximate delays, whole cycles.
   localparam int C_INV_GATE = T_INV_GATE_NS / NS_PER_CLK;
   localparam int C_GATE_ADR = T_GATE_ADR_NS / NS_PER_CLK;
   localparam int C_ADR_PROG = T_ADR_PROG_NS / NS_PER_CLK;
   localparam int C_PULSE    = T_PULSE_NS / NS_PER_CLK;
   localparam int C_END_GATE = T_END_GATE_NS / NS_PER_CLK;
   localparam int C_GATE_SEL = T_GATE_SEL_NS / NS_PER_CLK;
   localparam int C_REST     = T_REST_NS / NS_PER_CLK;

   // ****************************************************************
   // Counts and field layout
   // ****************************************************************
   localparam int MAX_ATTEMPTS = 49;
   localparam int ADDR_W       = 12;
   localparam int WORD_ADDR_W  = 8;
   localparam int DATA_W       = 8;
   localparam int CNT_W        = 20;
   localparam int TRY_W        = 8;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      EPS_ST_NONE,
      EPS_ST_OK,
      EPS_ST_ADDR_ERR,
      EPS_ST_HW_ERR,
      EPS_ST_PROG_FAIL
   } eps_status_t;

   typedef enum {
      EPS_IDLE,
      EPS_READ,
      EPS_SEL,
      EPS_INV,
      EPS_GATE,
      EPS_TRUE_ADR,
      EPS_PULSE,
      EPS_END_PULSE,
      EPS_END_GATE,
      EPS_REST,
      EPS_CHECK
   } eps_fsm_t;

   typedef struct packed {
      logic read_program_select;
      logic address_invert;
      logic gate_supply_pulse;
      logic program_supply_pulse;
      logic data_enable;
   } eps_ctrl_t;

   localparam eps_ctrl_t CTRL_RESET = '0;

   localparam logic [TRY_W-1:0] TRY_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;

endpackage

// ===== eps_sequencer.sv
// PROM word read and program sequencer for one 256-word PROM.
`timescale 1ns/1ps

module eps_sequencer
   import eps_pkg::*;
#(
   parameter int DLY_INV_GATE = C_INV_GATE,
   parameter int DLY_GATE_ADR = C_GATE_ADR,
   parameter int DLY_ADR_PROG = C_ADR_PROG,
   parameter int DLY_PULSE    = C_PULSE,
   parameter int DLY_END_GATE = C_END_GATE,
   parameter int DLY_GATE_SEL = C_GATE_SEL,
   parameter int DLY_REST     = C_REST
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   read_start,
   input  wire logic                   program_start,
   input  wire logic [ADDR_W-1:0]      prom_addr,
   input  wire logic [DATA_W-1:0]      write_data,
   input  wire logic                   high_voltage_present,
   input  wire logic                   compare_match,
   input  wire logic [DATA_W-1:0]      prom_data_in,
   output logic      [DATA_W-1:0]      prom_data_out,
   output logic                        prom_data_oe,
   output logic      [WORD_ADDR_W-1:0] prom_addr_out,
   output logic      [DATA_W-1:0]      prom_read_bus_n,
   output eps_ctrl_t                   ctrl,
   output logic                        busy,
   output logic                        done,
   output eps_status_t                 status
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      eps_fsm_t                fsm;
      eps_ctrl_t               ctrl;
      logic [CNT_W-1:0]        cnt;
      logic [TRY_W-1:0]        tries;
      logic [TRY_W-1:0]        extra;
      logic                    verified;
      logic [2:0]              hv_sync;
      logic                    hv;
      logic [WORD_ADDR_W-1:0]  addr_out;
      logic [DATA_W-1:0]       data_out;
      logic [DATA_W-1:0]       rd_out;
      logic                    done;
      eps_status_t             status;
   } eps_state_t;

   eps_state_t state_reg;
   eps_state_t state_next;

   logic addr_err;

   // Address range check on the top four address bits.
   assign addr_err = |prom_addr[ADDR_W-1:WORD_ADDR_W];

   // Converts a delay in cycles to a counter preload.
   function automatic logic [CNT_W-1:0] preload(input int cycles);
      int c;
      c = (cycles < 1) ? 1 : cycles;
      return CNT_W'(c - 1);
   endfunction

   // Next-state logic for the sequencer.
   always_comb
   begin
      state_next      = state_reg;
      state_next.done = 1'b0;
      // High-voltage flag filtered through three stages.
      state_next.hv_sync = {state_reg.hv_sync[1:0], high_voltage_present};
      if (state_reg.hv_sync[2] == state_reg.hv_sync[1])
      begin
         state_next.hv = state_reg.hv_sync[2];
      end
      // Address is complemented while invert is high.
      state_next.addr_out = state_reg.ctrl.address_invert ?
         ~prom_addr[WORD_ADDR_W-1:0] : prom_addr[WORD_ADDR_W-1:0];
      // Write data goes out inverted in program mode.
      state_next.data_out = ~write_data;
      // Read data returned only with data enable asserted.
      state_next.rd_out = state_reg.ctrl.data_enable ?
         ~prom_data_in : 8'hff;
      if (state_reg.cnt != CNT_RESET)
      begin
         state_next.cnt = state_reg.cnt - 1'b1;
      end
      unique case (state_reg.fsm)
         EPS_IDLE:
         begin
            // Separate entry points for read and program.
            if (read_start || program_start)
            begin
               // A new request ends the previous read's data enable.
               state_next.ctrl.data_enable = 1'b0;
               state_next.tries    = TRY_RESET;
               state_next.extra    = TRY_RESET;
               state_next.verified = 1'b0;
               state_next.status   = EPS_ST_NONE;
               if (addr_err)
               begin
                  state_next.status = EPS_ST_ADDR_ERR;
                  state_next.done   = 1'b1;
               end
               else if (read_start)
               begin
                  state_next.ctrl.data_enable = 1'b1;
                  state_next.fsm = EPS_READ;
               end
               else if (!state_reg.hv)
               begin
                  state_next.status = EPS_ST_HW_ERR;
                  state_next.done   = 1'b1;
               end
               else
               begin
                  state_next.fsm = EPS_SEL;
               end
            end
         end
         EPS_READ:
         begin
            // Data enable stays on until the next request.
            state_next.status = EPS_ST_OK;
            state_next.done   = 1'b1;
            state_next.fsm    = EPS_IDLE;
         end
         EPS_SEL:
         begin
            state_next.ctrl.read_program_select = 1'b1;
            state_next.fsm = EPS_INV;
         end
         EPS_INV:
         begin
            state_next.ctrl.address_invert = 1'b1;
            state_next.cnt = preload(DLY_INV_GATE);
            state_next.fsm = EPS_GATE;
         end
         EPS_GATE:
         begin
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.ctrl.gate_supply_pulse = 1'b1;
               state_next.cnt = preload(DLY_GATE_ADR);
               state_next.fsm = EPS_TRUE_ADR;
            end
         end
         EPS_TRUE_ADR:
         begin
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.ctrl.address_invert = 1'b0;
               state_next.cnt = preload(DLY_ADR_PROG);
               state_next.fsm = EPS_PULSE;
            end
         end
         EPS_PULSE:
         begin
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.ctrl.program_supply_pulse = 1'b1;
               state_next.cnt = preload(DLY_PULSE);
               state_next.fsm = EPS_END_PULSE;
            end
         end
         EPS_END_PULSE:
         begin
            // Outputs held for the whole pulse.
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.ctrl.program_supply_pulse = 1'b0;
               state_next.cnt = preload(DLY_END_GATE);
               state_next.fsm = EPS_END_GATE;
            end
         end
         EPS_END_GATE:
         begin
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.ctrl.gate_supply_pulse = 1'b0;
               state_next.cnt = preload(DLY_GATE_SEL);
               state_next.fsm = EPS_REST;
            end
         end
         EPS_REST:
         begin
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.ctrl.read_program_select = 1'b0;
               state_next.cnt = preload(DLY_REST);
               state_next.fsm = EPS_CHECK;
            end
         end
         EPS_CHECK:
         begin
            // Read-after-write compare after the rest period.
            if (state_reg.cnt == CNT_RESET)
            begin
               state_next.fsm = EPS_SEL;
               if (state_reg.verified)
               begin
                  if (state_reg.extra == 8'h01)
                  begin
                     state_next.status = EPS_ST_OK;
                     state_next.done   = 1'b1;
                     state_next.fsm    = EPS_IDLE;
                  end
                  state_next.extra = state_reg.extra - 1'b1;
               end
               else if (compare_match)
               begin
                  state_next.verified = 1'b1;
                  // 4N+5 with N = tries + 1.
                  state_next.extra = TRY_W'({state_reg.tries, 2'b00})
                     + 8'h09;
               end
               else if (state_reg.tries == TRY_W'(MAX_ATTEMPTS - 1))
               begin
                  state_next.status = EPS_ST_PROG_FAIL;
                  state_next.done   = 1'b1;
                  state_next.fsm    = EPS_IDLE;
               end
               else
               begin
                  state_next.tries = state_reg.tries + 1'b1;
               end
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_reg          <= '0;
         state_reg.fsm      <= EPS_IDLE;
         state_reg.ctrl     <= CTRL_RESET;
         state_reg.rd_out   <= 8'hff;
         state_reg.status   <= EPS_ST_NONE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs.
   assign prom_data_out   = state_reg.data_out;
   assign prom_data_oe    = state_reg.ctrl.read_program_select;
   assign prom_addr_out   = state_reg.addr_out;
   assign prom_read_bus_n = state_reg.rd_out;
   assign ctrl            = state_reg.ctrl;
   assign busy            = (state_reg.fsm != EPS_IDLE);
   assign done            = state_reg.done;
   assign status          = state_reg.status;

endmodule

// ===== eps_properties.sv
// Checker of the sequencer's port timing.
`timescale 1ns/1ps
module eps_properties
   import eps_pkg::*;
#(
   parameter int DLY_INV_GATE = C_INV_GATE,
   parameter int DLY_GATE_ADR = C_GATE_ADR,
   parameter int DLY_ADR_PROG = C_ADR_PROG,
   parameter int DLY_PULSE    = C_PULSE,
   parameter int DLY_END_GATE = C_END_GATE,
   parameter int DLY_GATE_SEL = C_GATE_SEL
)
(
   input wire logic              sys_clk,
   input wire logic              srst,
   input wire logic              read_start,
   input wire logic              program_start,
   input wire logic [ADDR_W-1:0] prom_addr,
   input wire logic              busy,
   input wire logic              done,
   input wire eps_status_t       status,
   input wire eps_ctrl_t         ctrl
);
   // ****************************************************************
   // Pulse sequence timing, address error and read checks
   // ****************************************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic rps, inv, gat, prg;
   logic take;
   // Short names for the supply controls and an accepted request.
   assign {rps, inv, gat, prg} = ctrl[4:1];
   assign take = (read_start || program_start) && !busy;
   // Cycles since the program pulse and the gate pulse last ended.
   // The end checks hold in both directions, so the end delays are counted.
   // Both counters rest at all ones until their first falling edge.
   logic [CNT_W-1:0] since_prg;
   logic [CNT_W-1:0] since_gat;
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         since_prg <= '1;
         since_gat <= '1;
      end
      else
      begin
         if ($fell(prg))
            since_prg <= CNT_W'(1);
         else if (!(&since_prg))
            since_prg <= since_prg + 1'b1;
         if ($fell(gat))
            since_gat <= CNT_W'(1);
         else if (!(&since_gat))
            since_gat <= since_gat + 1'b1;
      end
   end
   property p_inv;
      $rose(rps) |=> $rose(inv);
   endproperty
   a_inv: assert property (p_inv) else $error("invert late");
   property p_gate;
      $rose(inv) |-> ##DLY_INV_GATE $rose(gat);
   endproperty
   a_gate: assert property (p_gate) else $error("gate late");
   property p_true;
      $rose(gat) |-> ##DLY_GATE_ADR $fell(inv);
   endproperty
   a_true: assert property (p_true) else $error("true late");
   property p_prog;
      $fell(inv) |-> ##DLY_ADR_PROG $rose(prg);
   endproperty
   a_prog: assert property (p_prog) else $error("pulse late");
   property p_hold;
      $rose(prg) |-> ##DLY_PULSE $fell(prg) && gat && rps;
   endproperty
   a_hold: assert property (p_hold) else $error("pulse length");
   property p_ungate;
      $fell(gat) == (since_prg == CNT_W'(DLY_END_GATE));
   endproperty
   a_ungate: assert property (p_ungate) else $error("gate end");
   property p_unsel;
      $fell(rps) == (since_gat == CNT_W'(DLY_GATE_SEL));
   endproperty
   a_unsel: assert property (p_unsel) else $error("select end");
   property p_err;
      take && prom_addr[11:8] != 4'h0 |=> done && status == EPS_ST_ADDR_ERR;
   endproperty
   a_err: assert property (p_err) else $error("range");
   property p_read;
      take && read_start && prom_addr[11:8] == 4'h0
         |=> ctrl.data_enable ##1 done && status == EPS_ST_OK;
   endproperty
   a_read: assert property (p_read) else $error("read");
endmodule

bind eps_sequencer eps_properties #(.DLY_INV_GATE(DLY_INV_GATE),
   .DLY_GATE_ADR(DLY_GATE_ADR), .DLY_ADR_PROG(DLY_ADR_PROG),
   .DLY_PULSE(DLY_PULSE), .DLY_END_GATE(DLY_END_GATE),
   .DLY_GATE_SEL(DLY_GATE_SEL)) u_props (.sys_clk(sys_clk), .srst(srst),
   .read_start(read_start), .program_start(program_start),
   .prom_addr(prom_addr), .busy(busy), .done(done), .status(status),
   .ctrl(ctrl));

// ===== eps_prom_model.sv
// Behavioural PROM and supervisor comparator.
`timescale 1ns/1ps
module eps_prom_model
   import eps_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              clr,
   input  wire logic [7:0]        need,
   input  wire logic [7:0]        cmp_data,
   input  wire logic [7:0]        prom_addr_out,
   input  wire logic [7:0]        prom_data_out,
   input  wire logic              prom_data_oe,
   input  wire eps_ctrl_t         ctrl,
   output logic      [7:0]        prom_data_in,
   output logic      [7:0]        pulse_count
   ,output logic                  compare_match
);
   logic [7:0] mem [256];
   logic       pulse_reg;
   // The pins show the sequencer's driven value in program mode, else the word.
   assign prom_data_in = prom_data_oe ? prom_data_out : mem[prom_addr_out];
   // Read-after-write compare made by the supervisor.
   assign compare_match = (mem[prom_addr_out] == cmp_data);
   // A word takes only after the set number of program pulses.
   always @(posedge sys_clk)
   begin
      pulse_reg <= ctrl.program_supply_pulse;
      if (clr)
         pulse_count <= 8'h00;
      else if (pulse_reg && !ctrl.program_supply_pulse)
      begin
         pulse_count <= pulse_count + 8'h01;
         if (pulse_count + 8'h01 >= need)
            mem[prom_addr_out] <= ~prom_data_out;
      end
   end
   // An erased part reads all zero.
   initial
   begin
      foreach (mem[k])
         mem[k] = 8'h00;
   end
endmodule

// ===== tb_top.sv
// Self-checking bench for the PROM word sequencer.
`timescale 1ns/1ps
module tb_top
   import eps_pkg::*;
;
   logic              sys_clk, srst, read_start, program_start, clr;
   logic              high_voltage_present, compare_match, busy, done;
   logic              prom_data_oe;
   logic [ADDR_W-1:0] prom_addr;
   logic [7:0]        write_data, prom_data_in, prom_data_out, need;
   logic [7:0]        prom_read_bus_n, prom_addr_out, pulse_count;
   eps_ctrl_t         ctrl;
   eps_status_t       status;
   logic [11:0]       bad [3] = '{12'h100, 12'h800, 12'hfff};
   int                mismatches, n_tests, n;
   // Sequencer with the long delays shortened, and the far side.
   // The two gate-end delays keep their full length.
   eps_sequencer #(.DLY_INV_GATE(3), .DLY_GATE_ADR(4), .DLY_ADR_PROG(3),
      .DLY_PULSE(6), .DLY_REST(4)) uut (
      .sys_clk(sys_clk), .srst(srst), .read_start(read_start),
      .program_start(program_start), .prom_addr(prom_addr),
      .write_data(write_data), .high_voltage_present(high_voltage_present),
      .compare_match(compare_match), .prom_data_in(prom_data_in),
      .prom_data_out(prom_data_out), .prom_data_oe(prom_data_oe),
      .prom_addr_out(prom_addr_out), .prom_read_bus_n(prom_read_bus_n),
      .ctrl(ctrl), .busy(busy), .done(done), .status(status));
   eps_prom_model u_prom (.sys_clk(sys_clk), .clr(clr), .need(need),
      .cmp_data(write_data), .prom_addr_out(prom_addr_out),
      .prom_data_out(prom_data_out), .prom_data_oe(prom_data_oe),
      .ctrl(ctrl), .prom_data_in(prom_data_in),
      .pulse_count(pulse_count), .compare_match(compare_match));
   // Clock of 50 ns period.
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Sets address and data, starts one request and waits for done.
   task automatic op(input logic rd, input logic [11:0] a,
                     input logic [7:0] d);
      int i;
      @(negedge sys_clk);
      prom_addr = a;
      write_data = d;
      @(negedge sys_clk);
      read_start = rd;
      program_start = !rd;
      for (i = 0; i < 50000; i++)
      begin
         @(negedge sys_clk);
         read_start = 1'b0;
         program_start = 1'b0;
         if (done === 1'b1)
            break;
      end
      if (i == 50000)
      begin
         mismatches++;
         finish_test();
      end
   endtask
   // Main sequence of tests.
   initial
   begin
      srst = 1'b1; read_start = 1'b0; program_start = 1'b0; clr = 1'b1;
      prom_addr = 12'h000; write_data = 8'h00; need = 8'h01;
      high_voltage_present = 1'b0; mismatches = 0; n_tests = 0;
      repeat (3) @(negedge sys_clk);
      srst = 1'b0;
      clr = 1'b0;
      chk({status, busy, ctrl, prom_read_bus_n}, {3'h0, 6'h00, 8'hff});
      $display("reset test done");
      foreach (bad[k])
      begin
         op(k[0] == 1'b0, bad[k], 8'h00);
         repeat (3) @(negedge sys_clk);
         chk(status, EPS_ST_ADDR_ERR);
         chk(pulse_count, 8'h00);
      end
      $display("address test done");
      op(1'b0, 12'h0ff, 8'h55);
      chk(status, EPS_ST_HW_ERR);
      chk(pulse_count, 8'h00);
      $display("hardware test done");
      high_voltage_present = 1'b1;
      repeat (6) @(negedge sys_clk);
      for (n = 1; n <= 3; n += 2)
      begin
         need = 8'(n);
         clr = 1'b1;
         @(negedge sys_clk);
         clr = 1'b0;
         op(1'b0, 12'(8'ha0 + n), 8'(8'h3c ^ n));
         chk(pulse_count, 5 * n + 5);
         chk(status, EPS_ST_OK);
         chk(ctrl, 5'h00);
         op(1'b1, 12'(8'ha0 + n), 8'h00);
         chk(prom_read_bus_n, 8'(~(8'h3c ^ n)));
         chk(ctrl.data_enable, 1'b1);
      end
      $display("program test done");
      need = 8'hff;
      clr = 1'b1;
      @(negedge sys_clk);
      clr = 1'b0;
      op(1'b0, 12'h010, 8'h81);
      chk(pulse_count, 49);
      chk(status, EPS_ST_PROG_FAIL);
      $display("fail test done");
      finish_test();
   end
endmodule
